// >>> shared/mfr_defs.svh
// Constants for the multi-pin read front end
`ifndef MFR_DEFS_SVH
`define MFR_DEFS_SVH
// Opcodes taken on one lane
`define MFR_OP_DUAL     8'hBB
`define MFR_OP_DUAL_DTR 8'hBD
`define MFR_OP_QUAD     8'hEB
// Bit counts per phase
`define MFR_OP_LAST     6'h07
`define MFR_AM_BITS     6'h20
`define MFR_STEP_DUAL   6'h02
`define MFR_STEP_QUAD   6'h04
// Dummy clock defaults, in link clocks
`define MFR_DUMMY_DUAL  4'h0
`define MFR_DUMMY_DTR   4'h4
`define MFR_DUMMY_QUAD  4'h4
// Mode byte code that skips the next opcode
`define MFR_SKIP_CODE   2'h2
// Wrap setting: bit 0 disables (active low enable), bits 2:1 length
`define MFR_WRAP_RESET  3'h1
`define MFR_WRAP_BASE   24'h00_0008
// Data path
`define MFR_BYTE_W      8
`define MFR_FIFO_DEPTH  16
`define MFR_FILL        8'hFF
`define MFR_BYTE_BITS   4'h8
`define MFR_OUT_DUAL    4'h2
`define MFR_OUT_QUAD    4'h4
`define MFR_OE_DUAL     4'h3
`define MFR_OE_QUAD     4'hF
// Synchroniser reset: clock low, select high, data low
`define MFR_SYNC_RESET  6'h10
`endif

// >>> shared/mfr_pkg.sv
// Types shared by the read front end
package mfr_pkg;
   // Frame sequencer states
   typedef enum logic [2:0] {
      MFR_ST_IDLE,
      MFR_ST_OPCODE,
      MFR_ST_ADDR,
      MFR_ST_DUMMY,
      MFR_ST_DATA,
      MFR_ST_IGNORE
   } mfr_state_t;
   // Read command kinds
   typedef enum logic [1:0] {
      MFR_CMD_DUAL,
      MFR_CMD_DUAL_DTR,
      MFR_CMD_QUAD
   } mfr_cmd_t;
endpackage

// >>> hdl/mfr_read_front.sv
// Multi-pin random read front end with data FIFO
`include "mfr_defs.svh"
`timescale 1ns/100ps
`default_nettype none

// Byte FIFO between the array side and the serialiser
module mfr_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
)
(
   input  wire logic             ref_clk,
   input  wire logic             reset,
   input  wire logic             flush,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];   // Storage, no reset needed
   logic [AW-1:0]    wr_reg;        // Write pointer
   logic [AW-1:0]    rd_reg;        // Read pointer
   logic [AW:0]      count_reg;     // Words held
   logic [AW:0]      count_next;
   logic             ready_reg;     // Registered not-full
   wire              push;
   wire              pop;

   // Pushes during a flush are dropped on purpose
   assign push       = in_valid & ready_reg & ~flush;
   assign pop        = out_valid & out_ready;
   assign out_valid  = count_reg != '0;
   assign out_data   = mem[rd_reg];
   assign in_ready   = ready_reg;
   assign count_next = flush ? '0 :
                       count_reg + (AW+1)'(push) - (AW+1)'(pop);

   // Storage write
   always_ff @(posedge ref_clk)
   begin
      if (push)
         mem[wr_reg] <= in_data;
   end

   // Pointers and level; ready is a flop so it never glitches
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         wr_reg    <= '0;
         rd_reg    <= '0;
         count_reg <= '0;
         ready_reg <= 1'b1;
      end
      else
      begin
         wr_reg    <= flush ? '0 : wr_reg + AW'(push);
         rd_reg    <= flush ? '0 : rd_reg + AW'(pop & ~flush);
         count_reg <= count_next;
         ready_reg <= count_next != (AW+1)'(DEPTH);
      end
   end
endmodule

// Link-facing read sequencer, oversampling the serial clock
module mfr_read_front
#(
   parameter logic [3:0] DUMMY_DUAL     = `MFR_DUMMY_DUAL,
   parameter logic [3:0] DUMMY_DUAL_DTR = `MFR_DUMMY_DTR,
   parameter logic [3:0] DUMMY_QUAD     = `MFR_DUMMY_QUAD
)
(
   input  wire logic        ref_clk,
   input  wire logic        reset,
   input  wire logic        spi_clk,
   input  wire logic        spi_cs_n,
   input  wire logic [3:0]  spi_io_in,
   output logic      [3:0]  spi_io_out,
   output logic      [3:0]  spi_io_oe,
   input  wire logic        quad_pins_permit,
   input  wire logic        wrap_load,
   input  wire logic [2:0]  burst_wrap_setting,
   input  wire logic        soft_reset,
   input  wire logic [7:0]  mem_data,
   input  wire logic        mem_valid,
   output logic             mem_ready,
   output logic      [23:0] fetch_addr,
   output logic             fetch_active,
   output logic             cont_armed
);
   // Pin synchroniser and edge finder
   logic [5:0]  sync1_reg;          // First stage, read by stage two only
   logic [5:0]  sync2_reg;          // Settled pin levels
   logic        sclk_prev_reg;      // Last settled serial clock
   logic        cs_prev_reg;        // Last settled select

   // Sequencer state
   mfr_pkg::mfr_state_t state_reg;
   mfr_pkg::mfr_state_t state_next;
   mfr_pkg::mfr_cmd_t   cmd_reg;    // Survives frames for skip mode
   logic [5:0]  bit_cnt_reg;        // Bits taken in this phase
   logic [31:0] sh_reg;             // Address and mode shifter
   logic [3:0]  dummy_reg;          // Dummy clocks left
   logic        cont_armed_reg;     // Next frame starts at address
   logic [2:0]  wrap_reg;           // Held wrap setting
   logic        wrap_on_reg;        // Wrap used in this frame
   logic [7:0]  out_sh_reg;         // Byte being shifted out
   logic [3:0]  out_left_reg;       // Bits left in that byte
   logic [3:0]  io_out_reg;
   logic [3:0]  io_oe_reg;
   logic [23:0] fetch_addr_reg;     // Array address being fetched
   logic        fetch_active_reg;

   // FIFO link
   logic        fifo_in_ready;
   logic        fifo_out_valid;
   logic [7:0]  fifo_out_data;

   // Decoded helpers
   wire         sclk_s  = sync2_reg[5];
   wire         cs_s    = sync2_reg[4];
   wire  [3:0]  io_s    = sync2_reg[3:0];
   wire         rise    = sclk_s & ~sclk_prev_reg;
   wire         fall    = ~sclk_s & sclk_prev_reg;
   wire         cs_fall = ~cs_s & cs_prev_reg;
   wire         is_quad = cmd_reg == mfr_pkg::MFR_CMD_QUAD;
   wire         is_dtr  = cmd_reg == mfr_pkg::MFR_CMD_DUAL_DTR;
   // The opcode's trailing fall is no address edge: the first rise opens
   wire         in_tick = rise
                          | (is_dtr & fall & (bit_cnt_reg != 6'h00));
   wire         out_tick = fall | (is_dtr & rise);
   wire  [5:0]  bit_step = is_quad ? `MFR_STEP_QUAD : `MFR_STEP_DUAL;
   wire  [5:0]  bit_inc  = bit_cnt_reg + bit_step;
   // Address lanes: two for dual, four for quad
   wire  [31:0] sh_in = is_quad ? {sh_reg[27:0], io_s}
                                : {sh_reg[29:0], io_s[1:0]};
   wire  [7:0]  op_byte = {sh_reg[6:0], io_s[0]};
   wire         in_op   = state_reg == mfr_pkg::MFR_ST_OPCODE;
   wire         in_addr = state_reg == mfr_pkg::MFR_ST_ADDR;
   wire         in_data = state_reg == mfr_pkg::MFR_ST_DATA;
   wire         op_done = in_op & rise & (bit_cnt_reg == `MFR_OP_LAST);
   wire         am_done = in_addr & in_tick & (bit_inc == `MFR_AM_BITS);
   // Opcodes arrive on one lane only, on rising edges even for double rate
   wire         op_dual = op_byte == `MFR_OP_DUAL;
   wire         op_dtr  = op_byte == `MFR_OP_DUAL_DTR;
   wire         op_quad = (op_byte == `MFR_OP_QUAD)
                          & quad_pins_permit;
   wire         op_ok   = op_dual | op_dtr | op_quad;
   // Only mode bits 5:4 are looked at; 3:0 are don't care
   wire         skip_next = sh_in[5:4] == `MFR_SKIP_CODE;
   wire  [3:0]  dummy_sel = is_quad ? DUMMY_QUAD :
                            is_dtr  ? DUMMY_DUAL_DTR :
                                      DUMMY_DUAL;
   // Serialiser feed
   wire         need_byte = out_left_reg == 4'h0;
   wire         pop  = in_data & out_tick & need_byte & fifo_out_valid;
   wire  [7:0]  out_src = ~need_byte     ? out_sh_reg :
                          fifo_out_valid ? fifo_out_data : `MFR_FILL;
   wire  [3:0]  out_step = is_quad ? `MFR_OUT_QUAD : `MFR_OUT_DUAL;
   wire  [3:0]  oe_lanes = is_quad ? `MFR_OE_QUAD : `MFR_OE_DUAL;
   wire  [3:0]  io_next  = is_quad ? out_src[7:4]
                                   : {2'h0, out_src[7:6]};
   wire  [7:0]  sh_out   = is_quad ? {out_src[3:0], 4'h0}
                                   : {out_src[5:0], 2'h0};
   wire  [3:0]  left_next = (need_byte ? `MFR_BYTE_BITS : out_left_reg)
                            - out_step;
   // Drive only from the first data edge, after the host let go
   wire  [3:0]  oe_next = (in_data & (out_tick | (|io_oe_reg)))
                          ? oe_lanes : 4'h0;
   // Fetch address, wrapping inside the aligned section
   // Section size minus one: low address bits that wrap
   wire  [23:0] wrap_mask = (`MFR_WRAP_BASE << wrap_reg[2:1])
                            - 24'h00_0001;
   wire  [23:0] addr_inc  = fetch_addr_reg + 24'h00_0001;
   wire  [23:0] addr_seq  = wrap_on_reg
                            ? ((fetch_addr_reg & ~wrap_mask)
                               | (addr_inc & wrap_mask))
                            : addr_inc;
   wire         push = mem_valid & fifo_in_ready & fetch_active_reg;

   // Data buffer; a slow array side simply leaves it empty
   mfr_fifo #(
      .WIDTH (`MFR_BYTE_W),
      .DEPTH (`MFR_FIFO_DEPTH)
   ) u_fifo (
      .ref_clk   (ref_clk),
      .reset     (reset),
      .flush     (cs_s),
      .in_valid  (mem_valid & fetch_active_reg),
      .in_ready  (fifo_in_ready),
      .in_data   (mem_data),
      .out_valid (fifo_out_valid),
      .out_ready (pop),
      .out_data  (fifo_out_data)
   );

   // Two flops on every pin before use
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         sync1_reg     <= `MFR_SYNC_RESET;
         sync2_reg     <= `MFR_SYNC_RESET;
         sclk_prev_reg <= 1'b0;
         cs_prev_reg   <= 1'b1;
      end
      else
      begin
         sync1_reg     <= {spi_clk, spi_cs_n, spi_io_in};
         sync2_reg     <= sync1_reg;
         sclk_prev_reg <= sclk_s;
         cs_prev_reg   <= cs_s;
      end
   end

   // Frame sequencer; deselect always wins
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         mfr_pkg::MFR_ST_IDLE:
            if (cs_fall)
               state_next = cont_armed_reg ? mfr_pkg::MFR_ST_ADDR
                                           : mfr_pkg::MFR_ST_OPCODE;
         mfr_pkg::MFR_ST_OPCODE:
            if (op_done)
               state_next = op_ok ? mfr_pkg::MFR_ST_ADDR
                                  : mfr_pkg::MFR_ST_IGNORE;
         mfr_pkg::MFR_ST_ADDR:
            if (am_done)
               state_next = (dummy_sel == 4'h0) ? mfr_pkg::MFR_ST_DATA
                                                : mfr_pkg::MFR_ST_DUMMY;
         mfr_pkg::MFR_ST_DUMMY:
            if (rise && dummy_reg == 4'h1)
               state_next = mfr_pkg::MFR_ST_DATA;
         mfr_pkg::MFR_ST_DATA,
         mfr_pkg::MFR_ST_IGNORE:
            state_next = state_reg;
         default:
            state_next = mfr_pkg::MFR_ST_IDLE;
      endcase
      if (cs_s)
         state_next = mfr_pkg::MFR_ST_IDLE;
   end

   // State, command and input shifting
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         state_reg   <= mfr_pkg::MFR_ST_IDLE;
         cmd_reg     <= mfr_pkg::MFR_CMD_DUAL;
         bit_cnt_reg <= 6'h00;
         sh_reg      <= 32'h0000_0000;
         dummy_reg   <= 4'h0;
      end
      else
      begin
         state_reg <= state_next;
         if (cs_fall || op_done)
            bit_cnt_reg <= 6'h00;
         else if (in_op && rise)
            bit_cnt_reg <= bit_cnt_reg + 6'h01;
         else if (in_addr && in_tick)
            bit_cnt_reg <= bit_inc;
         // Opcode on lane 0, then address and mode on two lanes (dual) or four (quad)
         if (in_op && rise)
            sh_reg <= {sh_reg[30:0], io_s[0]};
         else if (in_addr && in_tick)
            sh_reg <= sh_in;
         // Command kind kept for opcode-less frames
         if (op_done && op_ok)
            cmd_reg <= op_quad ? mfr_pkg::MFR_CMD_QUAD :
                       op_dtr  ? mfr_pkg::MFR_CMD_DUAL_DTR :
                                 mfr_pkg::MFR_CMD_DUAL;
         if (am_done)
            dummy_reg <= dummy_sel;
         else if (state_reg == mfr_pkg::MFR_ST_DUMMY && rise)
            dummy_reg <= dummy_reg - 4'h1;
      end
   end

   // Skip mode and wrap setting; software reset spares skip mode
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         cont_armed_reg <= 1'b0;
         wrap_reg       <= `MFR_WRAP_RESET;
         wrap_on_reg    <= 1'b0;
      end
      else
      begin
         if (am_done)
            cont_armed_reg <= skip_next;
         // A load in the same cycle as a software reset wins
         if (wrap_load)
            wrap_reg <= burst_wrap_setting;
         else if (soft_reset)
            wrap_reg <= `MFR_WRAP_RESET;
         if (am_done)
            wrap_on_reg <= is_quad & ~wrap_reg[0];
      end
   end

   // Fetch address toward the array
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         fetch_addr_reg   <= 24'h00_0000;
         fetch_active_reg <= 1'b0;
      end
      else
      begin
         if (am_done)
            fetch_addr_reg <= sh_in[31:8];
         else if (push)
            fetch_addr_reg <= addr_seq;
         if (cs_s)
            fetch_active_reg <= 1'b0;
         else if (am_done)
            fetch_active_reg <= 1'b1;
      end
   end

   // Output serialiser; an empty FIFO sends fill bytes
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         out_sh_reg   <= 8'h00;
         out_left_reg <= 4'h0;
         io_out_reg   <= 4'h0;
         io_oe_reg    <= 4'h0;
      end
      else
      begin
         io_oe_reg <= oe_next;
         if (!in_data)
            out_left_reg <= 4'h0;
         else if (out_tick)
         begin
            out_sh_reg   <= sh_out;
            out_left_reg <= left_next;
            io_out_reg   <= io_next;
         end
      end
   end

   assign spi_io_out   = io_out_reg;
   assign spi_io_oe    = io_oe_reg;
   assign mem_ready    = fifo_in_ready;
   assign fetch_addr   = fetch_addr_reg;
   assign fetch_active = fetch_active_reg;
   assign cont_armed   = cont_armed_reg;

   // Checks
   property p_oe_late;
      @(posedge ref_clk) disable iff (reset)
      $rose(|io_oe_reg) |-> $past(out_tick) && $past(in_data);
   endproperty
   a_oe_late: assert property (p_oe_late)
      else $error("pins driven before first data edge");

   property p_skip;
      @(posedge ref_clk) disable iff (reset)
      (in_op == 1'b0 && state_reg == mfr_pkg::MFR_ST_IDLE && cs_fall
       && cont_armed_reg && !cs_s) |=> in_addr;
   endproperty
   a_skip: assert property (p_skip)
      else $error("armed frame did not skip opcode");

   property p_no_skip;
      @(posedge ref_clk) disable iff (reset)
      (state_reg == mfr_pkg::MFR_ST_IDLE && cs_fall && !cont_armed_reg)
      |=> in_op;
   endproperty
   a_no_skip: assert property (p_no_skip)
      else $error("unarmed frame skipped opcode");

   property p_swr_keeps;
      @(posedge ref_clk) disable iff (reset)
      (soft_reset && !am_done) |=> $stable(cont_armed_reg);
   endproperty
   a_swr_keeps: assert property (p_swr_keeps)
      else $error("software reset changed skip mode");

   property p_quad_gate;
      @(posedge ref_clk) disable iff (reset)
      (op_done && op_byte == `MFR_OP_QUAD && !quad_pins_permit)
      |=> state_reg == mfr_pkg::MFR_ST_IGNORE || cs_s;
   endproperty
   a_quad_gate: assert property (p_quad_gate)
      else $error("quad read taken without permit");

   property p_quad_lanes;
      @(posedge ref_clk) disable iff (reset)
      ((|io_oe_reg) && $past(is_quad)) |-> io_oe_reg == `MFR_OE_QUAD;
   endproperty
   a_quad_lanes: assert property (p_quad_lanes)
      else $error("quad data not on four pins");

   property p_wrap;
      @(posedge ref_clk) disable iff (reset)
      (push && wrap_on_reg && !am_done
       && (fetch_addr_reg & wrap_mask) == wrap_mask)
      |=> (fetch_addr_reg & wrap_mask) == 24'h00_0000
          && (fetch_addr_reg & ~wrap_mask)
             == $past(fetch_addr_reg & ~wrap_mask);
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("fetch address left its wrap section");

   property p_wrap_reset;
      @(posedge ref_clk) disable iff (reset)
      (soft_reset && !wrap_load) |=> wrap_reg == `MFR_WRAP_RESET;
   endproperty
   a_wrap_reset: assert property (p_wrap_reset)
      else $error("wrap setting not restored");

   property p_dtr_edges;
      @(posedge ref_clk) disable iff (reset)
      (in_addr && is_dtr && fall && !am_done && !cs_s
       && bit_cnt_reg != 6'h00)
      |=> bit_cnt_reg == $past(bit_cnt_reg) + `MFR_STEP_DUAL;
   endproperty
   a_dtr_edges: assert property (p_dtr_edges)
      else $error("double rate missed a falling edge");

   c_quad_data: cover property (@(posedge ref_clk) pop && is_quad);
   c_skip: cover property (@(posedge ref_clk) cs_fall && cont_armed_reg);
   c_wrap: cover property (@(posedge ref_clk)
      push && wrap_on_reg && (fetch_addr_reg & wrap_mask) == wrap_mask);
endmodule
`default_nettype wire

// >>> tb/mfr_host_model.sv
// Host controller model for the serial read link
`timescale 1ns/100ps
`default_nettype none
module mfr_host_model
(
   output logic            spi_clk,
   output logic            spi_cs_n,
   output logic      [3:0] spi_io_in,
   input  wire logic [3:0] spi_io_out,
   input  wire logic [3:0] spi_io_oe
);
   logic [3:0] host_val;  // Level on lines the host holds
   logic [7:0] rx[$];     // Bytes read in the last frame

   // Device wins where it drives; released lines show the host's levels
   assign spi_io_in = (spi_io_oe & spi_io_out) | (~spi_io_oe & host_val);

   // Idle link: clock still, device deselected
   initial
   begin
      spi_clk = 1'b0;
      spi_cs_n = 1'b1;
      host_val = 4'h0;
   end

   // One transfer: full clock at single rate, one edge at double rate
   task automatic xfer(input logic [3:0] v, input logic dtr);
      begin
         host_val = v;
         if (dtr)
         begin
            #40 spi_clk = ~spi_clk;
            #40;
         end
         else
         begin
            #80 spi_clk = 1'b1;
            #80 spi_clk = 1'b0;
         end
      end
   endtask

   // Whole read frame; sampling late in the high phase gives margin
   task automatic frame(input logic op_on, input logic [7:0] op,
                        input int ln, input logic dtr,
                        input logic [31:0] am, input int dum, input int n);
      int         t;   // Transfers for address and mode
      logic [7:0] sh;  // Incoming byte
      begin
         rx = {};
         sh = 8'h00;
         t = 32 / ln;
         #7 spi_cs_n = 1'b0;
         // Opcode on one lane only, single rate
         if (op_on)
            for (int k = 7; k >= 0; k--)
               xfer({3'b000, op[k]}, 1'b0);
         for (int k = 0; k < t; k++)
            if (k < t - 4 / ln)
               xfer(4'((am >> (32 - ln * (k + 1))) & ((1 << ln) - 1)),
                    dtr);
            else
               xfer(~host_val, dtr);
         // Dummy clocks with the lines let go
         repeat (dum)
            xfer(~host_val, 1'b0);
         // Double rate: sample before each edge, both edges move data
         for (int b = 0; b < n * 8 / ln; b++)
         begin
            if (!dtr)
               #80 spi_clk = 1'b1;
            #78 sh = 8'((sh << ln) | (spi_io_in & 4'((1 << ln) - 1)));
            #2 spi_clk = dtr ? ~spi_clk : 1'b0;
            if (b % (8 / ln) == 8 / ln - 1)
               rx.push_back(sh);
         end
         #80 spi_cs_n = 1'b1;
      end
   endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the multi-pin read front end
`timescale 1ns/100ps
`default_nettype none
`include "mfr_defs.svh"
module tb_top;
   localparam logic [3:0] DQ = 4'h4;  // Quad dummy clocks
   localparam logic [3:0] DD = 4'h4;  // Double-rate dummy clocks
   logic        ref_clk;        // System clock
   logic        reset;          // Asynchronous reset
   logic        spi_clk;        // Host serial clock
   logic        spi_cs_n;       // Host select
   logic [3:0]  spi_io_in;      // Resolved data lines
   logic [3:0]  spi_io_out;     // Device drive
   logic [3:0]  spi_io_oe;      // Device enables
   logic        quad_pins_permit;
   logic        wrap_load;
   logic [2:0]  burst_wrap_setting;
   logic        soft_reset;
   logic [7:0]  mem_data;       // Array byte
   logic        mem_valid;
   logic        mem_ready;
   logic [23:0] fetch_addr;
   logic        fetch_active;
   logic        cont_armed;
   logic [3:0]  oe_seen;        // Enables seen in a frame
   logic        full_seen;      // Buffer refused the array
   logic        act_d;          // Fetch activity, delayed
   logic [23:0] first_addr;     // Start address of last fetch
   int          starts;         // Fetch starts
   int          mismatches;
   int          cmp_count;

   mfr_read_front
   #(
      .DUMMY_DUAL     (4'h0),
      .DUMMY_DUAL_DTR (DD),
      .DUMMY_QUAD     (DQ)
   )
   dut
   (
      .ref_clk            (ref_clk),
      .reset              (reset),
      .spi_clk            (spi_clk),
      .spi_cs_n           (spi_cs_n),
      .spi_io_in          (spi_io_in),
      .spi_io_out         (spi_io_out),
      .spi_io_oe          (spi_io_oe),
      .quad_pins_permit   (quad_pins_permit),
      .wrap_load          (wrap_load),
      .burst_wrap_setting (burst_wrap_setting),
      .soft_reset         (soft_reset),
      .mem_data           (mem_data),
      .mem_valid          (mem_valid),
      .mem_ready          (mem_ready),
      .fetch_addr         (fetch_addr),
      .fetch_active       (fetch_active),
      .cont_armed         (cont_armed)
   );

   mfr_host_model host
   (
      .spi_clk    (spi_clk),
      .spi_cs_n   (spi_cs_n),
      .spi_io_in  (spi_io_in),
      .spi_io_out (spi_io_out),
      .spi_io_oe  (spi_io_oe)
   );

   // 50 MHz system clock
   initial
   begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   // Array model: byte follows address, updated off the sampling edge
   always @(negedge ref_clk)
      mem_data <= fetch_addr[7:0] ^ 8'hC3;

   // Watch enables, buffer refusals and fetch starts
   always @(posedge ref_clk)
   begin
      act_d <= fetch_active;
      oe_seen <= oe_seen | spi_io_oe;
      if (fetch_active && !mem_ready)
         full_seen <= 1'b1;
      if (fetch_active && !act_d)
      begin
         first_addr <= fetch_addr;
         starts <= starts + 1;
      end
   end

   task automatic finish_test;
      begin
         $display("compares %0d mismatches %0d", cmp_count, mismatches);
         if (mismatches == 0 && cmp_count > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask

   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      begin
         cmp_count++;
         if (got !== exp)
         begin
            mismatches++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
         end
      end
   endtask

   // One frame, with the frame watches cleared first
   task automatic rd(input logic op_on, input logic [7:0] op, input int ln,
                     input logic dtr, input logic [23:0] a,
                     input logic [7:0] m, input int dum, input int n);
      begin
         @(negedge ref_clk);
         oe_seen = 4'h0;
         full_seen = 1'b0;
         host.frame(op_on, op, ln, dtr, {a, m}, dum, n);
         repeat (10) @(negedge ref_clk);
      end
   endtask

   // Compare bytes read; len 0 means a plain rising address
   task automatic check_data(input logic [23:0] a0, input int len);
      logic [23:0] a;
      begin
         for (int i = 0; i < host.rx.size(); i++)
         begin
            a = a0 + 24'(i);
            if (len > 0)
               a = (a0 & ~24'(len - 1)) | (a & 24'(len - 1));
            check(24'(host.rx[i]), 24'(a[7:0] ^ 8'hC3));
         end
      end
   endtask

   task automatic load_wrap(input logic [2:0] w);
      begin
         @(negedge ref_clk);
         burst_wrap_setting = w;
         wrap_load = 1'b1;
         @(negedge ref_clk);
         wrap_load = 1'b0;
      end
   endtask

   // Dual read with no dummy clocks
   task automatic t_dual;
      begin
         rd(1'b1, `MFR_OP_DUAL, 2, 1'b0, 24'h01_2345, 8'h00, 0, 5);
         check(first_addr, 24'h01_2345);
         check(24'(oe_seen), 24'h00_0003);
         check_data(24'h01_2345, 0);
      end
   endtask

   // All four mode codes; crossing an 8-byte edge shows wrap is off at reset
   task automatic t_modes;
      logic arm;
      begin
         arm = 1'b0;
         for (int c = 0; c < 4; c++)
         begin
            rd(!arm, `MFR_OP_QUAD, 4, 1'b0, 24'h00_1006 + 24'(c * 64),
               {2'b00, 2'(c), 4'h5}, int'(DQ), 3);
            arm = (c == 2);
            check(24'(cont_armed), 24'(arm));
            check(24'(oe_seen), 24'h00_000F);
            check_data(24'h00_1006 + 24'(c * 64), 0);
         end
      end
   endtask

   // Double-rate dual read, then an armed frame without opcode
   task automatic t_dtr;
      begin
         rd(1'b1, `MFR_OP_DUAL_DTR, 2, 1'b1, 24'hAB_CDEF, 8'h20, int'(DD), 2);
         check(first_addr, 24'hAB_CDEF);
         check(24'(oe_seen), 24'h00_0003);
         check_data(24'hAB_CDEF, 0);
         rd(1'b0, 8'h00, 2, 1'b1, 24'h13_5791, 8'h00, int'(DD), 0);
         check(first_addr, 24'h13_5791);
         check(24'(cont_armed), 24'h00_0000);
      end
   endtask

   // Quad read refused while quad pins are not permitted
   task automatic t_refuse;
      int s;
      begin
         s = starts;
         quad_pins_permit = 1'b0;
         rd(1'b1, `MFR_OP_QUAD, 4, 1'b0, 24'h00_2000, 8'h20, int'(DQ), 2);
         quad_pins_permit = 1'b1;
         check(24'(oe_seen), 24'h00_0000);
         check(24'(starts - s), 24'h00_0000);
         check(24'(cont_armed), 24'h00_0000);
      end
   endtask

   // Each wrap length, then wrapping off; long reads fill the buffer
   task automatic t_wrap;
      int          len;
      logic [23:0] a;
      begin
         for (int c = 0; c < 5; c++)
         begin
            len = (c < 4) ? (8 << c) : 0;
            load_wrap((c < 4) ? {2'(c), 1'b0} : 3'h7);
            a = 24'h12_3440 + 24'(len) - 24'h00_0003;
            rd(1'b1, `MFR_OP_QUAD, 4, 1'b0, a, 8'h00, int'(DQ),
               ((c < 4) ? len : 64) + 3);
            check_data(a, len);
            if (c == 3)
               check(24'(full_seen), 24'h00_0001);
         end
      end
   endtask

   // Software reset keeps the armed state, drops the wrap setting
   task automatic t_soft;
      begin
         load_wrap(3'h0);
         rd(1'b1, `MFR_OP_QUAD, 4, 1'b0, 24'h00_3006, 8'h20, int'(DQ), 3);
         check_data(24'h00_3006, 8);
         @(negedge ref_clk);
         soft_reset = 1'b1;
         @(negedge ref_clk);
         soft_reset = 1'b0;
         check(24'(cont_armed), 24'h00_0001);
         rd(1'b0, 8'h00, 4, 1'b0, 24'h00_3006, 8'h00, int'(DQ), 3);
         check_data(24'h00_3006, 0);
      end
   endtask

   // Hang guard
   initial
   begin
      repeat (100000) @(posedge ref_clk);
      mismatches++;
      finish_test;
   end

   // Main sequence
   initial
   begin
      reset = 1'b1;
      quad_pins_permit = 1'b1;
      wrap_load = 1'b0;
      burst_wrap_setting = 3'h1;
      soft_reset = 1'b0;
      mem_data = 8'h00;
      mem_valid = 1'b1;
      oe_seen = 4'h0;
      full_seen = 1'b0;
      act_d = 1'b0;
      first_addr = 24'h00_0000;
      starts = 0;
      mismatches = 0;
      cmp_count = 0;
      repeat (6) @(negedge ref_clk);
      reset = 1'b0;
      check(24'({spi_io_oe, mem_ready, fetch_active, cont_armed}), 24'h4);
      check(fetch_addr, 24'h00_0000);
      t_dual;
      t_modes;
      t_dtr;
      t_refuse;
      t_wrap;
      t_soft;
      finish_test;
   end
endmodule
`default_nettype wire
